// File: logic/btm_pkg.sv
// constants and types shared by the board test-mode logic
package btm_pkg;
  localparam int NUM_PINS = 208;
  localparam int PIN_MODE_SEL = 99;
  localparam int PIN_STRAP = 65;
  localparam int PIN_POWER_GOOD = 59;
  localparam int PIN_DRIVE_SEL = 146;
  localparam int PIN_NAND_OUT = 25;
  localparam int QUAL_HI_N = 2;
  localparam int QUAL_HI_PINS [QUAL_HI_N] = '{146, 103};
  localparam int QUAL_LO_N = 6;
  localparam int QUAL_LO_PINS [QUAL_LO_N] = '{29, 50, 100, 108, 145, 94};
  localparam int KEEP_N = 7;
  localparam int KEEP_PINS [KEEP_N] = '{161, 163, 167, 180, 181, 183, 184};
  localparam int NAND_LEN = 133;
  localparam int NAND_PINS [NAND_LEN] = '{
    206, 207, 208, 1, 2, 3, 4, 5, 6, 7, 11, 12, 13, 14, 16, 17, 18, 19, 20, 21, 22, 23, 24, 26, 28, 29, 30,
    31, 32, 33, 34, 35, 36,
    39, 40, 41, 42, 47, 50, 51, 52, 54, 55, 56, 57, 58, 59, 62, 63, 64, 65, 66, 67, 68, 69, 70, 71, 72, 73,
    74, 75, 76, 77, 80, 81, 82,
    83, 84, 85, 86, 87, 88, 89, 90, 91, 92, 93, 94, 100, 101, 103, 105, 108, 109, 110, 111, 112, 113, 116,
    117, 118, 121, 122, 123, 124, 125, 126, 127, 128, 129,
    131, 132, 133, 134, 135, 136, 137, 138, 139, 140, 143, 144, 145, 146, 148, 149, 150, 151, 152, 153, 154,
    155, 156, 157, 168, 169, 170, 171, 192, 197, 198, 199, 202};

  typedef enum logic {ST_NORMAL, ST_TEST} btm_state_e;
  typedef enum logic [1:0] {MD_FUNC, MD_TRISTATE, MD_DRIVE_HI, MD_DRIVE_LO} btm_mode_e;

  // bit position of a pin number in the pad vectors
  function automatic int pin_idx(input int pin);
    pin_idx = pin - 1;
  endfunction : pin_idx
endpackage : btm_pkg

// File: logic/btm_nand_chain.sv
// registered nand-tree chain over the selected input pins
`timescale 1ns/100ps
module btm_nand_chain
  import btm_pkg::*;
#(
  parameter int LEN = NAND_LEN
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [LEN-1:0] chain_in,
  output logic chain_out_r
);
  logic chain_out_nxt;

  always_comb
  begin
    chain_out_nxt = chain_in[0];
    for (int i = 1; i < LEN; i++)
    begin
      chain_out_nxt = ~(chain_out_nxt & chain_in[i]); // RULE12
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      chain_out_r <= 1'b0;
    end
    else
    begin
      chain_out_r <= chain_out_nxt;
    end
  end
endmodule : btm_nand_chain

// File: logic/btm_test_ctrl.sv
// board test-mode control: entry qualification, tristate, nand tree and drive patterns
// Contract
// RULE1: in test mode offer tristate, nand tree, drive-high and drive-low functions only
// RULE2: tester holds pins 146,103 high and 29,50,100,108,145,94 low to qualify
// RULE3: every rising edge of pin 99 captures the pattern; match enters test mode
// RULE4: mismatched pattern keeps the device out of test mode, normal operation
// RULE5: pin 65 must read high at power-good rising edge before test mode allowed
// RULE6: pin 99 high in test mode tristates nearly all output and bidirectional pins
// RULE7: pins 161,163,167,180,181,183,184 stay driven during tristate
// RULE8: nand tree chains listed pins from pin 206 in order, result on pin 25
// RULE9: nand tree runs while pin 99 high in test mode, alongside tristate
// RULE10: pin 99 low in test mode runs drive test; pin 146 picks high or low
// RULE11: select 0 drives odd pins low, even high; select 1 the reverse
// RULE12: each nand stage combines previous stage with next chained pin
// RULE13: outside test mode pins are functional; power-good low clears test state
`timescale 1ns/100ps
module btm_test_ctrl
  import btm_pkg::*;
#(
  parameter int PINS = NUM_PINS
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] func_out,
  input wire logic [PINS-1:0] func_oe,
  output logic [PINS-1:0] pin_out_r,
  output logic [PINS-1:0] pin_oe_r,
  output logic test_mode_r,
  output btm_mode_e mode_r
);
  logic [PINS-1:0] pin_s1_r;
  logic [PINS-1:0] pin_s2_r;
  logic power_good_in;
  logic mode_sel;
  logic pg_d_r;
  logic sel_d_r;
  logic strap_ok_r;
  logic strap_ok_nxt;
  btm_state_e state_r;
  btm_state_e state_nxt;
  btm_mode_e mode_nxt;
  logic pattern_ok;
  logic test_mode_nxt;
  logic [NAND_LEN-1:0] chain_in;
  logic chain_out;
  logic [PINS-1:0] pin_out_nxt;
  logic [PINS-1:0] pin_oe_nxt;
  logic [PINS-1:0] keep_mask;

  // two-stage synchroniser for every pad input
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign power_good_in = pin_s2_r[pin_idx(PIN_POWER_GOOD)];
  assign mode_sel = pin_s2_r[pin_idx(PIN_MODE_SEL)];

  // qualifying pattern, checked on the synchronised copies
  always_comb
  begin
    pattern_ok = 1'b1;
    for (int i = 0; i < QUAL_HI_N; i++)
    begin
      pattern_ok = pattern_ok & pin_s2_r[pin_idx(QUAL_HI_PINS[i])]; // RULE2
    end
    for (int i = 0; i < QUAL_LO_N; i++)
    begin
      pattern_ok = pattern_ok & ~pin_s2_r[pin_idx(QUAL_LO_PINS[i])]; // RULE2
    end
  end

  // pads that stay driven in tristate, and the chain inputs in chain order
  always_comb
  begin
    keep_mask = '0;
    for (int i = 0; i < KEEP_N; i++)
    begin
      keep_mask[pin_idx(KEEP_PINS[i])] = 1'b1;
    end
    for (int i = 0; i < NAND_LEN; i++)
    begin
      chain_in[i] = pin_s2_r[pin_idx(NAND_PINS[i])]; // RULE8
    end
  end

  // entry state machine
  always_comb
  begin
    state_nxt = state_r;
    strap_ok_nxt = strap_ok_r;
    if (!power_good_in)
    begin
      state_nxt = ST_NORMAL; // RULE13
      strap_ok_nxt = 1'b0; // RULE13
    end
    else
    begin
      // strap is looked at only on the power-good rise, never later
      if (!pg_d_r)
      begin
        strap_ok_nxt = pin_s2_r[pin_idx(PIN_STRAP)]; // RULE5
      end
      // every select rise re-latches the pattern, so a bad one also leaves test mode
      if (mode_sel && !sel_d_r)
      begin
        case (state_r)
          ST_NORMAL,
          ST_TEST:
          begin
            state_nxt = (pattern_ok && strap_ok_r) ? ST_TEST : ST_NORMAL; // RULE3 RULE4 RULE5
          end
          default:
          begin
            state_nxt = ST_NORMAL;
          end
        endcase
      end
    end
  end

  // test function and pad drive
  always_comb
  begin
    test_mode_nxt = (state_nxt == ST_TEST);
    if (!test_mode_nxt)
    begin
      mode_nxt = MD_FUNC; // RULE13
    end
    else if (mode_sel)
    begin
      mode_nxt = MD_TRISTATE; // RULE6 RULE9
    end
    else if (pin_s2_r[pin_idx(PIN_DRIVE_SEL)])
    begin
      mode_nxt = MD_DRIVE_LO; // RULE10
    end
    else
    begin
      mode_nxt = MD_DRIVE_HI; // RULE10
    end
    pin_out_nxt = func_out;
    pin_oe_nxt = func_oe;
    case (mode_r) // RULE1
      MD_FUNC:
      begin
        pin_out_nxt = func_out;
        pin_oe_nxt = func_oe;
      end
      MD_TRISTATE:
      begin
        // tristate and the nand tree share the select level: pin 25 carries the chain
        pin_oe_nxt = func_oe & keep_mask; // RULE6 RULE7
        pin_out_nxt[pin_idx(PIN_NAND_OUT)] = chain_out; // RULE8 RULE9
        pin_oe_nxt[pin_idx(PIN_NAND_OUT)] = 1'b1; // RULE9
      end
      MD_DRIVE_HI,
      MD_DRIVE_LO:
      begin
        // every pad is driven here, input-only ones included
        pin_oe_nxt = '1;
        for (int i = 0; i < PINS; i++)
        begin
          // even index is an odd pin number
          pin_out_nxt[i] = ((i % 2) == 0) ? (mode_r == MD_DRIVE_LO) : (mode_r != MD_DRIVE_LO); // RULE11
        end
      end
      default:
      begin
        pin_out_nxt = func_out;
        pin_oe_nxt = func_oe;
      end
    endcase
  end

  // edge history, entry state and registered pad drive
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pg_d_r <= 1'b0;
      sel_d_r <= 1'b0;
      strap_ok_r <= 1'b0;
      state_r <= ST_NORMAL;
      mode_r <= MD_FUNC;
      test_mode_r <= 1'b0;
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end
    else
    begin
      pg_d_r <= power_good_in;
      sel_d_r <= mode_sel;
      strap_ok_r <= strap_ok_nxt;
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      test_mode_r <= test_mode_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  // chain result is registered once more through the pad flops
  btm_nand_chain #(
    .LEN(NAND_LEN)
  ) u_chain (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .chain_in(chain_in),
    .chain_out_r(chain_out)
  );
endmodule : btm_test_ctrl

// File: tb/btm_ate_model.sv
// tester model driving the pads
`timescale 1ns/100ps
module btm_ate_model
  import btm_pkg::*;
(
  input wire logic ref_clk,
  output logic [NUM_PINS-1:0] pins
);
  initial pins = '0;
  // each change is held six cycles to clear the synchronisers
  task automatic put(input int p, input logic v);
    pins[p-1] = v;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : put
  task automatic power(input logic s);
    put(59, 1'b0);
    put(65, s);
    put(59, 1'b1);
  endtask : power
  // pattern with pin bad turned wrong (none when bad is 0), then a select rise
  task automatic qualify(input int bad);
    foreach (QUAL_HI_PINS[i]) pins[QUAL_HI_PINS[i]-1] = (bad != QUAL_HI_PINS[i]);
    foreach (QUAL_LO_PINS[i]) pins[QUAL_LO_PINS[i]-1] = (bad == QUAL_LO_PINS[i]);
    put(99, 1'b0);
    put(99, 1'b1);
  endtask : qualify
  task automatic rnd(input logic [NUM_PINS-1:0] r);
    foreach (NAND_PINS[i]) pins[NAND_PINS[i]-1] = r[i];
    put(59, 1'b1);
  endtask : rnd
endmodule : btm_ate_model

// File: tb/btm_test_ctrl_assertions.sv
// port assertions for the board test-mode control
`timescale 1ns/100ps
module btm_test_ctrl_assertions
  import btm_pkg::*;
#(
  parameter int PINS = NUM_PINS
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] func_oe,
  input wire logic [PINS-1:0] pin_out_r,
  input wire logic [PINS-1:0] pin_oe_r,
  input wire logic test_mode_r,
  input wire btm_mode_e mode_r
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  wire sel = pin_in[98];
  wire pg = pin_in[58];
  wire ok = &{pin_in[145], pin_in[102], ~pin_in[28], ~pin_in[49], ~pin_in[99], ~pin_in[107], ~pin_in[144], ~pin_in[93]};
  sequence sel_rise;
    $rose(sel) && pg;
  endsequence
  chk_func_pass: assert property ($past(rst_n) && mode_r == MD_FUNC |=> pin_oe_r == $past(func_oe))
    else $error("pads not functional");
  chk_bad_pattern: assert property (sel_rise ##0 !ok |-> ##3 !test_mode_r)
    else $error("entry on bad pattern");
  chk_entry_cause: assert property ($rose(test_mode_r) |-> $past(ok, 3) && $past(sel, 3) && !$past(sel, 4))
    else $error("entry without cause");
  chk_pg_clear: assert property (!pg |-> ##3 !test_mode_r)
    else $error("test kept without power");
  chk_mode_flag: assert property (test_mode_r == (mode_r != MD_FUNC))
    else $error("mode and flag differ");
  chk_drive_sel: assert property ($fell(sel) && mode_r == MD_TRISTATE && pg
    |-> ##3 mode_r == ($past(pin_in[145], 3) ? MD_DRIVE_LO : MD_DRIVE_HI))
    else $error("wrong drive mode");
  chk_drive_pat: assert property (mode_r == MD_DRIVE_HI |=> &pin_oe_r && pin_out_r == {(PINS/2){2'b10}})
    else $error("wrong drive pattern");
  chk_tri_keep: assert property (mode_r == MD_TRISTATE
    |=> !pin_oe_r[0] && pin_oe_r[24] && pin_oe_r[160] == $past(func_oe[160]))
    else $error("wrong tristate");
endmodule : btm_test_ctrl_assertions
bind btm_test_ctrl btm_test_ctrl_assertions #(.PINS(PINS)) chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .pin_in(pin_in), .func_oe(func_oe), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r), .test_mode_r(test_mode_r),
  .mode_r(mode_r));

// File: tb/tb_top.sv
// self-checking bench for the board test-mode control
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t %0h %0h", $time, a, b); end end
module tb_top;
  import btm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_PINS-1:0] pin_in, func_out, func_oe, pin_out_r, pin_oe_r, m;
  logic test_mode_r, nand_prev;
  btm_mode_e mode_r;
  int err_count = 0, num_checks = 0, seed = 32'hae3680ab, k;
  int q[$] = {146, 103, 29, 50, 100, 108, 145, 94};
  always #5 ref_clk = ~ref_clk;
  btm_ate_model ate_i (.ref_clk(ref_clk), .pins(pin_in));
  btm_test_ctrl btm_test_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .pin_in(pin_in), .func_out(func_out),
    .func_oe(func_oe), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r), .test_mode_r(test_mode_r), .mode_r(mode_r));
  function automatic logic chain();
    logic v;
    v = pin_in[NAND_PINS[0]-1];
    for (int j = 1; j < NAND_LEN; j++) v = ~(v & pin_in[NAND_PINS[j]-1]);
    return v;
  endfunction : chain
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end
  initial
  begin
    func_out = NUM_PINS'({7{$random(seed)}});
    func_oe = NUM_PINS'({7{$random(seed)}});
    m = '0;
    foreach (KEEP_PINS[i]) m[KEEP_PINS[i]-1] = 1'b1;
    m[24] = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 `CHK(pin_oe_r, func_oe)
    ate_i.power(1'b0);
    ate_i.qualify(0);
    `CHK(test_mode_r, 1'b0)
    ate_i.power(1'b1);
    foreach (q[i])
    begin
      ate_i.qualify(q[i]);
      `CHK(test_mode_r, 1'b0)
    end
    ate_i.qualify(0);
    `CHK(mode_r, MD_TRISTATE)
    `CHK(pin_oe_r, (func_oe & m) | (NUM_PINS'(1) << (PIN_NAND_OUT - 1)))
    repeat (20)
    begin
      ate_i.rnd(NUM_PINS'({7{$random(seed)}}));
      `CHK(pin_out_r[24], chain())
      k = NAND_PINS[{$random(seed)} % NAND_LEN];
      if (k != 59)
        ate_i.put(k, !pin_in[k-1]);
      `CHK(pin_out_r[24], chain())
    end
    // all chain inputs high: dropping one input flips the chain output only at chain position 0 or an odd position
    ate_i.rnd('1);
    `CHK(pin_out_r[PIN_NAND_OUT - 1], chain())
    nand_prev = pin_out_r[PIN_NAND_OUT - 1];
    k = NAND_PINS[{$random(seed)} % NAND_LEN];
    if (k == PIN_POWER_GOOD)
      k = NAND_PINS[0];
    ate_i.put(k, 1'b0);
    `CHK(pin_out_r[PIN_NAND_OUT - 1], ~nand_prev)
    `CHK(pin_out_r[PIN_NAND_OUT - 1], chain())
    `CHK(mode_r, MD_TRISTATE)
    ate_i.put(146, 1'b0);
    ate_i.put(99, 1'b0);
    `CHK(mode_r, MD_DRIVE_HI)
    `CHK(pin_out_r, {104{2'b10}})
    `CHK(pin_oe_r, {NUM_PINS{1'b1}})
    ate_i.put(146, 1'b1);
    `CHK(mode_r, MD_DRIVE_LO)
    `CHK(pin_out_r, {104{2'b01}})
    ate_i.put(59, 1'b0);
    `CHK(test_mode_r, 1'b0)
    `CHK(pin_out_r, func_out)
    end_of_test();
  end
endmodule : tb_top
